/* rtl/irq_resp_pkg.sv */
package irq_resp_pkg;

  // Fixed restart addresses
  localparam logic [15:0] NMI_VECTOR = 16'h0066;
  localparam logic [15:0] RST_A_VECTOR = 16'h003C;
  localparam logic [15:0] RST_B_VECTOR = 16'h0034;
  localparam logic [15:0] RST_C_VECTOR = 16'h002C;
  localparam logic [15:0] MODE1_VECTOR = 16'h0038;

  // Mask register layout, one enable bit per maskable input
  localparam int MASK_BIT_MM = 0;
  localparam int MASK_BIT_A = 1;
  localparam int MASK_BIT_B = 2;
  localparam int MASK_BIT_C = 3;
  localparam logic [3:0] MASK_RESET = 4'h1;

  // Multi-mode input modes
  localparam logic [1:0] MODE_JAM = 2'h0;
  localparam logic [1:0] MODE_RESTART = 2'h1;
  localparam logic [1:0] MODE_INDIRECT = 2'h2;
  localparam logic [1:0] MODE_RESET = 2'h0;
  localparam logic [7:0] PAGE_RESET = 8'h00;

  // Jammed opcode decode
  localparam logic [7:0] OPC_CALL = 8'hCD;
  localparam logic [7:0] OPC_RST_MASK = 8'hC7;
  localparam logic [7:0] OPC_RST_MATCH = 8'hC7;
  localparam int OPC_RST_LSB = 3;

  // T-state and instruction-end counts (one T-state per clk_sys cycle)
  localparam logic [1:0] EXTRA_TSTATES = 2'h2;
  localparam logic [1:0] EI_HOLD_ENDS = 2'h2;

  typedef enum logic [2:0] {
    SRC_NONE, SRC_NMI, SRC_A, SRC_B, SRC_C, SRC_MM
  } src_t;

  typedef struct packed {
    logic req;
    logic we;
    logic [15:0] addr;
    logic [7:0] wdata;
  } mem_cmd_t;

  typedef struct packed {
    logic load;
    logic [15:0] value;
  } word_load_t;

endpackage

/* rtl/irq_priority_arbiter.sv */
`timescale 1ns/1ps
module irq_priority_arbiter (
  // Pending non-maskable request, and maskable requests already gated by enables and masks
  input wire logic nmi_pending,
  input wire logic [3:0] eligible,
  // Winning source
  output irq_resp_pkg::src_t grant
);
  import irq_resp_pkg::*;

  // Fixed order, no external daisy chain needed
  always_comb begin
    if (nmi_pending) begin
      grant = SRC_NMI;
    end else if (eligible[MASK_BIT_A]) begin
      grant = SRC_A;
    end else if (eligible[MASK_BIT_B]) begin
      grant = SRC_B;
    end else if (eligible[MASK_BIT_C]) begin
      grant = SRC_C;
    end else if (eligible[MASK_BIT_MM]) begin
      grant = SRC_MM;
    end else begin
      grant = SRC_NONE;
    end
  end

endmodule // irq_priority_arbiter

/* rtl/cpu_interrupt_response_unit.sv */
`timescale 1ns/1ps
module cpu_interrupt_response_unit (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Interrupt inputs
  input wire logic nmi_request,
  input wire logic restart_req_a,
  input wire logic restart_req_b,
  input wire logic restart_req_c,
  input wire logic multimode_request,
  // Core sequencing
  input wire logic instr_end,
  input wire logic [15:0] program_counter,
  input wire logic [15:0] stack_pointer,
  input wire logic jam_more,
  // Core instructions affecting interrupt state
  input wire logic ei_exec,
  input wire logic di_exec,
  input wire logic retn_exec,
  input wire logic mask_wr,
  input wire logic [3:0] mask_wdata,
  input wire logic mode_wr,
  input wire logic [1:0] mode_wdata,
  input wire logic page_wr,
  input wire logic [7:0] page_wdata,
  // Acknowledge cycle on the data bus
  output logic irq_acknowledge_strobe,
  input wire logic [7:0] bus_data_in,
  // Stack and table memory access
  output irq_resp_pkg::mem_cmd_t mem_cmd,
  input wire logic [7:0] mem_rdata,
  // Results for the core
  output logic busy,
  output irq_resp_pkg::word_load_t pc_update,
  output irq_resp_pkg::word_load_t sp_update,
  output logic jam_valid,
  output logic [7:0] jam_byte,
  // Status
  output logic irq_enable_ff,
  output logic irq_enable_shadow_ff,
  output logic [3:0] irq_mask_reg,
  output logic [1:0] irq_mode,
  output irq_resp_pkg::src_t active_source
);
  import irq_resp_pkg::*;

  typedef enum logic [3:0] {
    ST_IDLE, ST_ACK_T1, ST_ACK_T2, ST_ACK_T3, ST_EXTRA,
    ST_PUSH_HI, ST_PUSH_LO, ST_TBL_LO, ST_TBL_HI, ST_JUMP
  } state_t;

  state_t state;
  src_t grant;
  logic nmi_prev;
  logic nmi_pending;
  logic [3:0] level_in;
  logic [3:0] eligible;
  logic [7:0] page_reg;
  logic [1:0] ei_hold;
  logic accept;
  logic maskable_accept;
  logic [15:0] pc_save;
  logic [15:0] sp_save;
  logic [15:0] target;
  logic [7:0] ack_byte;
  logic [1:0] ack_idx;
  logic [1:0] extra_cnt;
  logic [7:0] tbl_lo;
  logic [15:0] table_ptr;
  logic mode2_run;

  assign level_in[MASK_BIT_MM] = multimode_request;
  assign level_in[MASK_BIT_A] = restart_req_a;
  assign level_in[MASK_BIT_B] = restart_req_b;
  assign level_in[MASK_BIT_C] = restart_req_c;

  // Levels only, no edge memory: a dropped request is simply gone
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_elig
      assign eligible[gi] = level_in[gi] & irq_mask_reg[gi] & irq_enable_ff
        & irq_enable_shadow_ff & (ei_hold == 2'h0);
    end
  endgenerate

  irq_priority_arbiter u_arb (
    .nmi_pending(nmi_pending),
    .eligible(eligible),
    .grant(grant)
  );

  assign accept = instr_end && (state == ST_IDLE) && (grant != SRC_NONE);
  assign maskable_accept = accept && (grant != SRC_NMI);
  assign busy = (state != ST_IDLE);
  assign mode2_run = (active_source == SRC_MM) && (irq_mode == MODE_INDIRECT);
  assign table_ptr = {page_reg, ack_byte};

  // Non-maskable edge latch; no enable touches it, and a new edge wins over the clear
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      nmi_prev <= 1'b0;
      nmi_pending <= 1'b0;
    end else begin
      nmi_prev <= nmi_request;
      if (nmi_request && !nmi_prev) begin
        nmi_pending <= 1'b1;
      end else if (accept && grant == SRC_NMI) begin
        nmi_pending <= 1'b0;
      end
    end
  end

  // Enable pair; shadow keeps the old state across a non-maskable service
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      irq_enable_ff <= 1'b0;
      irq_enable_shadow_ff <= 1'b0;
    end else if (maskable_accept) begin
      irq_enable_ff <= 1'b0;
      irq_enable_shadow_ff <= 1'b0;
    end else if (accept) begin
      irq_enable_ff <= 1'b0;
    end else if (ei_exec) begin
      irq_enable_ff <= 1'b1;
      irq_enable_shadow_ff <= 1'b1;
    end else if (di_exec) begin
      irq_enable_ff <= 1'b0;
      irq_enable_shadow_ff <= 1'b0;
    end else if (retn_exec) begin
      irq_enable_ff <= irq_enable_shadow_ff;
    end
  end

  // Holds off maskables through the first two instruction ends after enable
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ei_hold <= 2'h0;
    end else if (ei_exec) begin
      ei_hold <= EI_HOLD_ENDS;
    end else if (instr_end && ei_hold != 2'h0) begin
      ei_hold <= ei_hold - 2'h1;
    end
  end

  // Program-written settings
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      irq_mask_reg <= MASK_RESET;
      irq_mode <= MODE_RESET;
      page_reg <= PAGE_RESET;
    end else begin
      if (mask_wr) begin
        irq_mask_reg <= mask_wdata;
      end
      if (mode_wr && mode_wdata != 2'h3) begin
        irq_mode <= mode_wdata;
      end
      if (page_wr) begin
        page_reg <= page_wdata;
      end
    end
  end

  // Response sequencer
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state <= ST_IDLE;
      active_source <= SRC_NONE;
      pc_save <= 16'h0000;
      sp_save <= 16'h0000;
      target <= 16'h0000;
      ack_byte <= 8'h00;
      ack_idx <= 2'h0;
      extra_cnt <= 2'h0;
      tbl_lo <= 8'h00;
      jam_valid <= 1'b0;
      jam_byte <= 8'h00;
      pc_update <= '0;
      sp_update <= '0;
    end else begin
      jam_valid <= 1'b0;
      pc_update.load <= 1'b0;
      sp_update.load <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (accept) begin
            active_source <= grant;
            pc_save <= program_counter;
            sp_save <= stack_pointer;
            ack_idx <= 2'h0;
            extra_cnt <= 2'h0;
            case (grant)
              SRC_NMI: target <= NMI_VECTOR;
              SRC_A: target <= RST_A_VECTOR;
              SRC_B: target <= RST_B_VECTOR;
              SRC_C: target <= RST_C_VECTOR;
              default: target <= MODE1_VECTOR;
            endcase
            if (grant == SRC_MM && irq_mode == MODE_RESTART) begin
              state <= ST_EXTRA;
            end else if (grant == SRC_MM) begin
              state <= ST_ACK_T1;
            end else begin
              state <= ST_PUSH_HI;
            end
          end
        end
        ST_ACK_T1: state <= ST_ACK_T2;
        ST_ACK_T2: begin
          ack_byte <= bus_data_in;
          state <= ST_ACK_T3;
        end
        ST_ACK_T3: begin
          if (irq_mode == MODE_INDIRECT) begin
            state <= ST_EXTRA;
          end else if (ack_idx == 2'h1) begin
            target[7:0] <= ack_byte;
            ack_idx <= 2'h2;
            state <= ST_ACK_T1;
          end else if (ack_idx == 2'h2) begin
            target[15:8] <= ack_byte;
            state <= ST_EXTRA;
          end else if ((ack_byte & OPC_RST_MASK) == OPC_RST_MATCH) begin
            target <= {10'h000, ack_byte[OPC_RST_LSB +: 3], 3'h0};
            state <= ST_EXTRA;
          end else if (ack_byte == OPC_CALL) begin
            ack_idx <= 2'h1;
            state <= ST_ACK_T1;
          end else begin
            // Other jammed opcodes go to the core, which asks for more bytes
            jam_valid <= 1'b1;
            jam_byte <= ack_byte;
            state <= jam_more ? ST_ACK_T1 : ST_IDLE;
          end
        end
        ST_EXTRA: begin
          extra_cnt <= extra_cnt + 2'h1;
          if (extra_cnt == EXTRA_TSTATES - 2'h1) begin
            state <= ST_PUSH_HI;
          end
        end
        ST_PUSH_HI: state <= ST_PUSH_LO;
        ST_PUSH_LO: begin
          sp_update.load <= 1'b1;
          sp_update.value <= sp_save - 16'h0002;
          state <= mode2_run ? ST_TBL_LO : ST_JUMP;
        end
        ST_TBL_LO: state <= ST_TBL_HI;
        ST_TBL_HI: begin
          tbl_lo <= mem_rdata;
          state <= ST_JUMP;
        end
        ST_JUMP: begin
          pc_update.load <= 1'b1;
          pc_update.value <= mode2_run ? {mem_rdata, tbl_lo} : target;
          state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Strobe only in the second T-state of each acknowledge cycle
  assign irq_acknowledge_strobe = (state == ST_ACK_T2);

  // Stack pushes high byte first; table read low byte first
  always_comb begin
    mem_cmd = '0;
    if (state == ST_PUSH_HI) begin
      mem_cmd = '{req: 1'b1, we: 1'b1, addr: sp_save - 16'h0001,
        wdata: pc_save[15:8]};
    end else if (state == ST_PUSH_LO) begin
      mem_cmd = '{req: 1'b1, we: 1'b1, addr: sp_save - 16'h0002, wdata: pc_save[7:0]};
    end else if (state == ST_TBL_LO) begin
      mem_cmd = '{req: 1'b1, we: 1'b0, addr: table_ptr, wdata: 8'h00};
    end else if (state == ST_TBL_HI) begin
      mem_cmd = '{req: 1'b1, we: 1'b0, addr: table_ptr + 16'h0001, wdata: 8'h00};
    end
  end

  AST_NMI_VECTOR: assert property (@(posedge clk_sys) disable iff (rst)
    pc_update.load && active_source == SRC_NMI |-> pc_update.value == NMI_VECTOR)
    else $error("non-maskable handler address wrong");

  AST_NMI_EDGE: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(nmi_pending) |-> $past(nmi_request) && !$past(nmi_prev))
    else $error("non-maskable pending without an input edge");

  AST_NMI_FIRST: assert property (@(posedge clk_sys) disable iff (rst)
    accept && nmi_pending |=> active_source == SRC_NMI)
    else $error("non-maskable request not served first");

  AST_MASK_GATE: assert property (@(posedge clk_sys) disable iff (rst)
    maskable_accept |-> irq_enable_ff && irq_enable_shadow_ff)
    else $error("maskable accepted with enables clear");

  AST_IFF_CLEAR: assert property (@(posedge clk_sys) disable iff (rst)
    maskable_accept |=> !irq_enable_ff && !irq_enable_shadow_ff)
    else $error("enables not cleared on maskable acceptance");

  AST_ACK_T2: assert property (@(posedge clk_sys) disable iff (rst)
    accept && grant == SRC_MM && irq_mode != MODE_RESTART
    |=> !irq_acknowledge_strobe ##1 irq_acknowledge_strobe ##1 !irq_acknowledge_strobe)
    else $error("acknowledge not in second T-state");

  AST_EXTRA_TWO: assert property (@(posedge clk_sys) disable iff (rst)
    state == ST_EXTRA && $past(state) != ST_EXTRA
    |=> state == ST_EXTRA ##1 state == ST_PUSH_HI)
    else $error("multi-mode response not two T-states longer");

  AST_PUSH_ORDER: assert property (@(posedge clk_sys) disable iff (rst)
    state == ST_PUSH_HI |-> mem_cmd.we && mem_cmd.addr == sp_save - 16'h0001
    ##1 mem_cmd.we && mem_cmd.wdata == pc_save[7:0] ##1 sp_update.load)
    else $error("counter push order or stack update wrong");

  AST_RST_JAM: assert property (@(posedge clk_sys) disable iff (rst)
    state == ST_ACK_T3 && irq_mode == MODE_JAM && ack_idx == 2'h0
    && (ack_byte & OPC_RST_MASK) == OPC_RST_MATCH
    |=> target == {10'h000, $past(ack_byte[5:3]), 3'h0})
    else $error("jammed restart address wrong");

endmodule // cpu_interrupt_response_unit

/* sim/irq_peripheral_model.sv */
`timescale 1ns/1ps
module irq_peripheral_model (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Acknowledge side
  input wire logic irq_acknowledge_strobe,
  input wire logic busy,
  input wire logic [23:0] resp_bytes,
  output logic [7:0] bus_data_in,
  output logic [1:0] ack_count,
  // Memory side
  input wire irq_resp_pkg::mem_cmd_t mem_cmd,
  output logic [7:0] mem_rdata,
  output logic [15:0] push_word,
  output logic [15:0] last_wr_addr
);
  import irq_resp_pkg::*;
  logic fresh;
  logic [7:0] last;
  logic [1:0] sel;
  assign sel = fresh ? 2'h0 : ack_count;
  // Released bus shows the inverse, so a late capture cannot pass by luck
  assign bus_data_in = irq_acknowledge_strobe ? resp_bytes[8 * sel +: 8] : ~last;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      fresh <= 1'b1;
      ack_count <= 2'h0;
      last <= 8'h00;
    end else if (irq_acknowledge_strobe) begin
      fresh <= 1'b0;
      ack_count <= fresh ? 2'h1 : ack_count + 2'h1;
      last <= bus_data_in;
    end else if (!busy) begin
      fresh <= 1'b1;
    end
  end
  // Table bytes derive from their address; even vectors only, low byte first
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mem_rdata <= 8'h00;
      push_word <= 16'h0000;
      last_wr_addr <= 16'h0000;
    end else if (mem_cmd.req && !mem_cmd.we) begin
      mem_rdata <= mem_cmd.addr[15:8] ^ mem_cmd.addr[7:0];
    end else begin
      mem_rdata <= ~mem_rdata;
      if (mem_cmd.req) begin
        push_word <= {push_word[7:0], mem_cmd.wdata};
        last_wr_addr <= mem_cmd.addr;
      end
    end
  end
endmodule // irq_peripheral_model

/* sim/cpu_interrupt_response_unit_tb.sv */
`timescale 1ns/1ps
module cpu_interrupt_response_unit_tb;
  import irq_resp_pkg::*;
  logic clk_sys, rst, nmi_request, multimode_request, instr_end, jam_more;
  logic restart_req_a, restart_req_b, restart_req_c;
  logic ei_exec, di_exec, retn_exec, mask_wr, mode_wr, page_wr;
  logic [3:0] mask_wdata, irq_mask_reg, reqs;
  logic [1:0] mode_wdata, irq_mode, ack_count;
  logic [7:0] page_wdata, bus_data_in, mem_rdata, jam_byte;
  logic [15:0] program_counter, stack_pointer, pcv, push_word, last_wr_addr;
  logic [23:0] resp_bytes;
  logic irq_acknowledge_strobe, busy, jam_valid, irq_enable_ff, irq_enable_shadow_ff;
  mem_cmd_t mem_cmd;
  word_load_t pc_update, sp_update;
  src_t active_source;
  int fail_count, compares, cycles;
  assign {restart_req_a, restart_req_b, restart_req_c, multimode_request} = reqs;

  cpu_interrupt_response_unit cpu_interrupt_response_unit_inst (.clk_sys(clk_sys), .rst(rst),
    .nmi_request(nmi_request), .restart_req_a(restart_req_a), .restart_req_b(restart_req_b),
    .restart_req_c(restart_req_c), .multimode_request(multimode_request),
    .instr_end(instr_end), .program_counter(program_counter), .stack_pointer(stack_pointer),
    .jam_more(jam_more), .ei_exec(ei_exec), .di_exec(di_exec), .retn_exec(retn_exec),
    .mask_wr(mask_wr), .mask_wdata(mask_wdata), .mode_wr(mode_wr), .mode_wdata(mode_wdata),
    .page_wr(page_wr), .page_wdata(page_wdata), .irq_acknowledge_strobe(irq_acknowledge_strobe),
    .bus_data_in(bus_data_in), .mem_cmd(mem_cmd), .mem_rdata(mem_rdata), .busy(busy),
    .pc_update(pc_update), .sp_update(sp_update), .jam_valid(jam_valid), .jam_byte(jam_byte),
    .irq_enable_ff(irq_enable_ff), .irq_enable_shadow_ff(irq_enable_shadow_ff),
    .irq_mask_reg(irq_mask_reg), .irq_mode(irq_mode), .active_source(active_source));

  irq_peripheral_model irq_peripheral_model_inst (.clk_sys(clk_sys), .rst(rst),
    .irq_acknowledge_strobe(irq_acknowledge_strobe), .busy(busy), .resp_bytes(resp_bytes),
    .bus_data_in(bus_data_in), .ack_count(ack_count), .mem_cmd(mem_cmd),
    .mem_rdata(mem_rdata), .push_word(push_word), .last_wr_addr(last_wr_addr));

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic end_instr();
    @(posedge clk_sys);
    instr_end <= 1'b1;
    @(posedge clk_sys);
    instr_end <= 1'b0;
  endtask

  task automatic cfg(input logic [3:0] m, input logic [1:0] md, input logic [7:0] pg);
    @(posedge clk_sys);
    {mask_wr, mode_wr, page_wr} <= 3'h7;
    {mask_wdata, mode_wdata, page_wdata} <= {m, md, pg};
    @(posedge clk_sys);
    {mask_wr, mode_wr, page_wr} <= 3'h0;
    #1;
    chk("mask", {12'h0, irq_mask_reg}, {12'h0, m});
    chk("mode", {14'h0, irq_mode}, {14'h0, md});
  endtask

  // Enable, then two instruction ends that must still be refused
  task automatic arm();
    @(posedge clk_sys);
    ei_exec <= 1'b1;
    @(posedge clk_sys);
    ei_exec <= 1'b0;
    repeat (2) begin
      end_instr();
      #1;
      chk("refused", {15'h0, busy}, 16'h0);
    end
  endtask

  task automatic fire(input string nm, input logic [15:0] epc, input src_t esrc, input int lat);
    int n;
    n = 0;
    pcv = pcv + 16'h0111;
    @(posedge clk_sys);
    program_counter <= pcv;
    instr_end <= 1'b1;
    @(posedge clk_sys);
    instr_end <= 1'b0;
    do begin
      @(posedge clk_sys);
      #1;
      n++;
    end while (pc_update.load !== 1'b1 && n < 40);
    chk(nm, pc_update.value, epc);
    chk("latency", n[15:0], lat[15:0]);
    chk("pushed pc", push_word, pcv);
    chk("stack addr", last_wr_addr, stack_pointer - 16'h2);
    chk("sp update", sp_update.value, stack_pointer - 16'h2);
    chk("source", {13'h0, active_source}, {13'h0, esrc});
    repeat (2) @(posedge clk_sys);
  endtask

  // Jammed opcode that is neither restart nor call goes to the core, no push
  task automatic jam_other(input logic [7:0] opc);
    int n;
    n = 0;
    resp_bytes <= {16'h0, opc};
    jam_more <= 1'b0;
    arm();
    @(posedge clk_sys);
    instr_end <= 1'b1;
    @(posedge clk_sys);
    instr_end <= 1'b0;
    do begin
      @(posedge clk_sys);
      #1;
      n++;
    end while (jam_valid !== 1'b1 && n < 40);
    chk("jam byte", {8'h0, jam_byte}, {8'h0, opc});
    chk("jam latency", n[15:0], 16'h3);
    @(posedge clk_sys);
    #1;
    chk("jam pulse", {14'h0, jam_valid, busy}, 16'h0);
    chk("ack count", {14'h0, ack_count}, 16'h1);
  endtask

  // Return from non-maskable service copies the shadow back
  task automatic retn_check();
    @(posedge clk_sys);
    retn_exec <= 1'b1;
    @(posedge clk_sys);
    retn_exec <= 1'b0;
    #1;
    chk("retn", {14'h0, irq_enable_ff, irq_enable_shadow_ff}, 16'h3);
  endtask

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      wrap_up();
    end
  end

  initial begin
    {rst, nmi_request, instr_end, jam_more, ei_exec, di_exec, retn_exec} = 7'h40;
    {mask_wr, mode_wr, page_wr, mask_wdata, mode_wdata, page_wdata, reqs} = '0;
    stack_pointer = 16'hF000;
    program_counter = 16'h0000;
    pcv = 16'h1000;
    resp_bytes = 24'h0;
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    #1;
    chk("enables", {14'h0, irq_enable_ff, irq_enable_shadow_ff}, 16'h0);
    chk("mask rst", {12'h0, irq_mask_reg}, {12'h0, MASK_RESET});
    chk("mode rst", {14'h0, irq_mode}, {14'h0, MODE_RESET});
    chk("busy rst", {15'h0, busy}, 16'h0);
    // Non-maskable with everything masked and disabled
    cfg(4'h0, MODE_JAM, 8'h00);
    @(posedge clk_sys);
    nmi_request <= 1'b1;
    fire("nmi", NMI_VECTOR, SRC_NMI, 3);
    nmi_request <= 1'b0;
    // Held levels, all pending at once, non-maskable on top
    cfg(4'hF, MODE_RESTART, 8'h40);
    reqs <= 4'hF;
    arm();
    nmi_request <= 1'b1;
    fire("nmi first", NMI_VECTOR, SRC_NMI, 3);
    chk("shadow kept", {14'h0, irq_enable_ff, irq_enable_shadow_ff}, 16'h1);
    nmi_request <= 1'b0;
    retn_check();
    for (int i = 0; i < 4; i++) begin
      arm();
      case (i)
        0: fire("rst a", RST_A_VECTOR, SRC_A, 3);
        1: fire("rst b", RST_B_VECTOR, SRC_B, 3);
        2: fire("rst c", RST_C_VECTOR, SRC_C, 3);
        default: fire("mode1", MODE1_VECTOR, SRC_MM, 5);
      endcase
      chk("cleared", {14'h0, irq_enable_ff, irq_enable_shadow_ff}, 16'h0);
      reqs[3 - i] <= 1'b0;
    end
    // Multi-mode masked off stays unanswered
    cfg(4'hE, MODE_JAM, 8'h40);
    reqs <= 4'h1;
    arm();
    end_instr();
    #1;
    chk("mm masked", {15'h0, busy}, 16'h0);
    cfg(4'h1, MODE_JAM, 8'h40);
    for (int k = 0; k < 8; k++) begin
      resp_bytes <= {16'h0, 2'b11, k[2:0], 3'b111};
      arm();
      fire("jam rst", {10'h0, k[2:0], 3'h0}, SRC_MM, 8);
      chk("ack count", {14'h0, ack_count}, 16'h1);
    end
    resp_bytes <= {8'h12, 8'h34, OPC_CALL};
    arm();
    fire("jam call", 16'h1234, SRC_MM, 14);
    chk("ack count", {14'h0, ack_count}, 16'h3);
    jam_other(8'h00);
    cfg(4'h1, MODE_INDIRECT, 8'h40);
    resp_bytes <= 24'h000012;
    arm();
    fire("indirect", 16'h5352, SRC_MM, 10);
    chk("ack count", {14'h0, ack_count}, 16'h1);
    wrap_up();
  end
endmodule // cpu_interrupt_response_unit_tb
